// ### core/plc_dp_pkg.sv
package plc_dp_pkg;

   // ------------------------------------------------------------
   // device reference layout
   // ------------------------------------------------------------
   // a reference is {device type, device index}
   localparam int TYPE_W = 3;
   // bit devices pack sixteen bits into one stored word
   localparam int BIT_SH = 4;
   localparam int WORD_W = 16;

   // device types; the bit types sort below the word types
   localparam logic [2:0] DEV_X = 3'h0;
   localparam logic [2:0] DEV_Y = 3'h1;
   localparam logic [2:0] DEV_M = 3'h2;
   localparam logic [2:0] DEV_S = 3'h3;
   localparam logic [2:0] DEV_T = 3'h4;
   localparam logic [2:0] DEV_C = 3'h5;
   localparam logic [2:0] DEV_D = 3'h6;
   localparam logic [2:0] DEV_W = 3'h7;

   // ------------------------------------------------------------
   // instruction codes
   // ------------------------------------------------------------
   localparam logic [1:0] OP_RANGE_CLEAR = 2'h0;
   localparam logic [1:0] OP_DECODE = 2'h1;
   localparam logic [1:0] OP_ENCODE = 2'h2;
   localparam logic [1:0] OP_BIT_COUNT = 2'h3;

   // ------------------------------------------------------------
   // error codes and operand limits
   // ------------------------------------------------------------
   // 6705 decimal: endpoints of a range clear do not match
   localparam logic [15:0] ERR_TYPE_MIX = 16'h1A31;
   // any other operand fault
   localparam logic [15:0] ERR_OPERAND = 16'h1A32;
   localparam logic [7:0] N_MAX_BIT = 8'h08;
   localparam logic [7:0] N_MAX_WORD = 8'h04;
   // first index of the 32-bit counters
   localparam int C32_BASE_DEF = 200;

   // ------------------------------------------------------------
   // sequencer states
   // ------------------------------------------------------------
   typedef enum logic [7:0] {
      S_IDLE = 8'h01,
      S_G_RD = 8'h02,
      S_G_WT = 8'h04,
      S_CALC = 8'h08,
      S_RD = 8'h10,
      S_WT = 8'h20,
      S_WR = 8'h40,
      S_DONE = 8'h80
   } state_t;

endpackage : plc_dp_pkg

// ### core/device_store.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// device memory: one write port, registered read data
// ------------------------------------------------------------
module device_store #(
   parameter int AW = 13, // word address width
   parameter int DW = 16 // word width
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic rd_en,
   input wire logic wr_en,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata
);

   // contents are not reset: device data survive a controller reset
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // write port
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[addr] <= wdata;
      end
   end

   // read data hold until the next read, so a read-modify-write
   // can use them one cycle later
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rdata <= '0;
      end else if (rd_en) begin
         rdata <= mem[addr];
      end
   end

endmodule : device_store

// ### core/plc_bit_data_processing_unit.sv
`timescale 1ns/1ps

module plc_bit_data_processing_unit
   import plc_dp_pkg::*;
#(
   parameter int IDX_W = 10, // device index width, at least 9
   parameter int C32_BASE = C32_BASE_DEF,
   localparam int REF_W = TYPE_W + IDX_W
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic drive_condition,
   input wire logic [1:0] op_code,
   input wire logic wide_mode,
   input wire logic [REF_W-1:0] opd_a,
   input wire logic [REF_W-1:0] opd_b,
   input wire logic [7:0] length_n,
   input wire logic err_clear,
   input wire logic [REF_W-1:0] host_addr,
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic [WORD_W-1:0] host_wdata,
   output logic [WORD_W-1:0] host_rdata,
   output logic busy,
   output logic done,
   output logic zero_flag,
   output logic error_flag,
   output logic [15:0] error_code_register
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   localparam int CNT_W = IDX_W + 1;
   localparam logic [IDX_W-1:0] C32_IDX = IDX_W'(C32_BASE);

   function automatic logic is_bit(input logic [TYPE_W-1:0] t);
      return t <= DEV_S;
   endfunction : is_bit

   // word address of element k counted from reference r
   function automatic logic [REF_W-1:0] elem_addr(
      input logic [REF_W-1:0] r, input logic [CNT_W-1:0] k);
      logic [IDX_W-1:0] pos;
      pos = r[IDX_W-1:0] + k[IDX_W-1:0];
      if (is_bit(r[REF_W-1 -: TYPE_W])) begin
         return {r[REF_W-1 -: TYPE_W], pos >> BIT_SH};
      end
      return {r[REF_W-1 -: TYPE_W], pos};
   endfunction : elem_addr

   // bit lane of element k inside its stored word
   function automatic logic [BIT_SH-1:0] elem_bit(
      input logic [REF_W-1:0] r, input logic [CNT_W-1:0] k);
      logic [IDX_W-1:0] pos;
      pos = r[IDX_W-1:0] + k[IDX_W-1:0];
      return pos[BIT_SH-1:0];
   endfunction : elem_bit

   // ones in the low w bits, w up to sixteen
   function automatic logic [15:0] low_mask(input logic [4:0] w);
      logic [16:0] m;
      m = (17'h00001 << w) - 17'h00001;
      return m[15:0];
   endfunction : low_mask

   function automatic logic [5:0] pop_count(input logic [31:0] v);
      logic [5:0] c;
      c = '0;
      for (int i = 0; i < 32; i++) begin
         c = c + {5'h00, v[i]};
      end
      return c;
   endfunction : pop_count

   function automatic logic [3:0] top_bit(input logic [15:0] v);
      logic [3:0] p;
      p = '0;
      for (int i = 0; i < 16; i++) begin
         if (v[i]) p = 4'(i);
      end
      return p;
   endfunction : top_bit

   function automatic logic [7:0] n_limit(input logic [TYPE_W-1:0] t);
      return is_bit(t) ? N_MAX_BIT : N_MAX_WORD;
   endfunction : n_limit

   // ------------------------------------------------------------
   // registers and wires
   // ------------------------------------------------------------
   state_t st_reg, st_next; // sequencer
   logic drive_d_reg; // drive condition one cycle back
   logic [1:0] op_reg; // latched instruction
   logic wide_reg; // latched 32-bit mode
   logic [REF_W-1:0] a_reg; // source reference
   logic [REF_W-1:0] d_reg; // destination or clear start
   logic [3:0] n_reg; // latched length, already checked
   logic [CNT_W-1:0] k_reg; // element counter
   logic [CNT_W-1:0] g_cnt_reg; // elements to gather
   logic [CNT_W-1:0] s_cnt_reg; // elements to write
   logic [31:0] gword_reg; // gathered source words
   logic [7:0] gidx_reg; // gathered decode index bits
   logic [7:0] gpos_reg; // highest set bit seen
   logic gfound_reg; // any set bit seen
   logic [15:0] res_reg; // computed index, position or count
   logic [TYPE_W-1:0] ta, tb; // operand types
   logic [IDX_W-1:0] ia, ib; // operand indices
   logic start_pulse; // rising drive while idle
   logic l_err, l_nop; // launch verdicts
   logic [15:0] l_code; // launch error code
   logic [CNT_W-1:0] l_gcnt, l_scnt; // launch element counts
   logic [REF_W-1:0] l_dst; // launch destination
   logic calc_err; // error found after gathering
   logic [15:0] enc_field; // word encode source, masked
   logic last_k; // counter at its final element
   logic mem_re, mem_we; // memory strobes
   logic [REF_W-1:0] mem_addr;
   logic [WORD_W-1:0] mem_wdata, mem_rdata;
   logic [BIT_SH-1:0] wbit; // lane touched by a bit write
   logic bit_val; // value for a bit write

   assign ta = opd_a[REF_W-1 -: TYPE_W];
   assign tb = opd_b[REF_W-1 -: TYPE_W];
   assign ia = opd_a[IDX_W-1:0];
   assign ib = opd_b[IDX_W-1:0];
   assign busy = st_reg != S_IDLE;
   assign done = st_reg == S_DONE;
   assign host_rdata = mem_rdata;
   assign wbit = elem_bit(d_reg, k_reg);
   assign enc_field = gword_reg[15:0] & low_mask(5'h01 << n_reg);

   // ------------------------------------------------------------
   // trigger
   // ------------------------------------------------------------
   // the drive condition comes from scan logic on this clock
   always_ff @(posedge sys_clk) begin
      if (!nrst) drive_d_reg <= 1'b0;
      else drive_d_reg <= drive_condition;
   end

   // once per edge
   // an edge that arrives while busy is dropped, not queued
   assign start_pulse = drive_condition & ~drive_d_reg &
      (st_reg == S_IDLE);

   // ------------------------------------------------------------
   // operand checks at launch
   // ------------------------------------------------------------
   always_comb begin
      l_err = 1'b0;
      l_nop = 1'b0;
      l_code = ERR_OPERAND;
      l_gcnt = '0;
      l_scnt = CNT_W'(1);
      l_dst = opd_b;
      unique case (op_code)
         OP_RANGE_CLEAR: begin
            l_dst = opd_a;
            if (ta == DEV_X) begin
               l_err = 1'b1;
            end else if (ta != tb || (ta == DEV_C &&
                  ((ia >= C32_IDX) != (ib >= C32_IDX)))) begin
               l_err = 1'b1;
               l_code = ERR_TYPE_MIX;
            end
            if (ia <= ib) l_scnt = CNT_W'(ib - ia) + CNT_W'(1);
         end
         OP_DECODE: begin
            if (tb == DEV_X || length_n > n_limit(tb)) l_err = 1'b1;
            else if (length_n == 8'h00) l_nop = 1'b1;
            l_gcnt = is_bit(ta) ? CNT_W'(length_n[3:0]) : CNT_W'(1);
            l_scnt = is_bit(tb) ? CNT_W'(1) << length_n[3:0]
               : CNT_W'(1);
         end
         OP_ENCODE: begin
            if (is_bit(tb) || length_n > n_limit(ta)) l_err = 1'b1;
            else if (length_n == 8'h00) l_nop = 1'b1;
            l_gcnt = is_bit(ta) ? CNT_W'(1) << length_n[3:0]
               : CNT_W'(1);
         end
         OP_BIT_COUNT: begin
            if (is_bit(ta) || is_bit(tb)) l_err = 1'b1;
            l_gcnt = wide_mode ? CNT_W'(2) : CNT_W'(1);
            l_scnt = l_gcnt;
         end
      endcase
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   assign last_k = (st_reg == S_G_WT) ? (k_reg + CNT_W'(1) == g_cnt_reg)
      : (k_reg + CNT_W'(1) == s_cnt_reg);

   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         S_IDLE: begin
            if (start_pulse) begin
               if (l_err || l_nop) st_next = S_DONE;
               else if (l_gcnt != '0) st_next = S_G_RD;
               else if (is_bit(l_dst[REF_W-1 -: TYPE_W])) st_next = S_RD;
               else st_next = S_WR;
            end
         end
         S_G_RD: st_next = S_G_WT;
         S_G_WT: st_next = last_k ? S_CALC : S_G_RD;
         S_CALC: begin
            if (calc_err) st_next = S_DONE;
            else if (is_bit(d_reg[REF_W-1 -: TYPE_W])) st_next = S_RD;
            else st_next = S_WR;
         end
         S_RD: st_next = S_WT;
         S_WT: st_next = last_k ? S_DONE : S_RD;
         S_WR: st_next = last_k ? S_DONE : S_WR;
         S_DONE: st_next = S_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) st_reg <= S_IDLE;
      else st_reg <= st_next;
   end

   // instruction latch and element counter
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         op_reg <= OP_RANGE_CLEAR;
         wide_reg <= 1'b0;
         a_reg <= '0;
         d_reg <= '0;
         n_reg <= '0;
         g_cnt_reg <= '0;
         s_cnt_reg <= '0;
         k_reg <= '0;
      end else if (start_pulse) begin
         op_reg <= op_code;
         wide_reg <= wide_mode;
         a_reg <= opd_a;
         d_reg <= l_dst;
         n_reg <= length_n[3:0];
         g_cnt_reg <= l_gcnt;
         s_cnt_reg <= l_scnt;
         k_reg <= '0;
      end else if (st_reg == S_G_WT || st_reg == S_WT ||
            st_reg == S_WR) begin
         k_reg <= last_k ? '0 : k_reg + CNT_W'(1);
      end
   end

   // ------------------------------------------------------------
   // source gathering
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst || start_pulse) begin
         gword_reg <= '0;
         gidx_reg <= '0;
         gpos_reg <= '0;
         gfound_reg <= 1'b0;
      end else if (st_reg == S_G_WT) begin
         if (!is_bit(a_reg[REF_W-1 -: TYPE_W])) begin
            gword_reg[k_reg[0]*16 +: 16] <= mem_rdata;
         end else if (op_reg == OP_DECODE) begin
            // low n bits form the index
            gidx_reg[k_reg[2:0]] <= mem_rdata[elem_bit(a_reg, k_reg)];
         end else if (mem_rdata[elem_bit(a_reg, k_reg)]) begin
            // later, higher bits overwrite lower ones
            gpos_reg <= k_reg[7:0];
            gfound_reg <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // result computation
   // ------------------------------------------------------------
   // empty encode source
   assign calc_err = (op_reg == OP_ENCODE) &&
      (is_bit(a_reg[REF_W-1 -: TYPE_W]) ? !gfound_reg
         : enc_field == 16'h0000);

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         res_reg <= '0;
      end else if (st_reg == S_CALC) begin
         unique case (op_reg)
            OP_DECODE: res_reg <= is_bit(a_reg[REF_W-1 -: TYPE_W]) ?
               {8'h00, gidx_reg} :
               gword_reg[15:0] & low_mask({1'b0, n_reg});
            OP_ENCODE: res_reg <= is_bit(a_reg[REF_W-1 -: TYPE_W]) ?
               {8'h00, gpos_reg} : {12'h000, top_bit(enc_field)};
            OP_BIT_COUNT: res_reg <= {10'h000, pop_count(wide_reg ?
               gword_reg : {16'h0000, gword_reg[15:0]})};
            default: res_reg <= '0;
         endcase
      end
   end

   // zero flag follows each bit count that passes its operand checks
   always_ff @(posedge sys_clk) begin
      if (!nrst) zero_flag <= 1'b0;
      else if (st_reg == S_CALC && op_reg == OP_BIT_COUNT)
         zero_flag <= (wide_reg ? gword_reg
            : {16'h0000, gword_reg[15:0]}) == 32'h00000000;
   end

   // sticky error; a new error wins over the clear
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         error_flag <= 1'b0;
         error_code_register <= '0;
      end else if (start_pulse && l_err) begin
         error_flag <= 1'b1;
         error_code_register <= l_code;
      end else if (st_reg == S_CALC && calc_err) begin
         error_flag <= 1'b1;
         error_code_register <= ERR_OPERAND;
      end else if (err_clear) begin
         error_flag <= 1'b0;
         error_code_register <= '0;
      end
   end

   // ------------------------------------------------------------
   // memory port
   // ------------------------------------------------------------
   // zero for cleared elements, one at the decoded index
   assign bit_val = (op_reg == OP_DECODE) &&
      (k_reg[7:0] == res_reg[7:0]);

   always_comb begin
      mem_re = 1'b0;
      mem_we = 1'b0;
      mem_addr = elem_addr(d_reg, k_reg);
      mem_wdata = '0;
      unique case (st_reg)
         S_G_RD: begin
            mem_re = 1'b1;
            mem_addr = elem_addr(a_reg, k_reg);
         end
         S_RD: mem_re = 1'b1;
         S_WT: begin
            mem_we = 1'b1;
            mem_wdata = mem_rdata;
            mem_wdata[wbit] = bit_val;
         end
         S_WR: begin
            mem_we = 1'b1;
            unique case (op_reg)
               // high bits of a word stay zero
               OP_DECODE: mem_wdata = 16'h0001 << res_reg[3:0];
               OP_ENCODE: mem_wdata = res_reg;
               // high word of a pair is zero
               OP_BIT_COUNT: mem_wdata = (k_reg == '0) ? res_reg : '0;
               default: mem_wdata = '0;
            endcase
         end
         S_IDLE: begin
            // scan logic owns the memory between instructions
            mem_re = host_rd;
            mem_we = host_wr;
            mem_addr = host_addr;
            mem_wdata = host_wdata;
         end
         default: mem_addr = elem_addr(d_reg, k_reg);
      endcase
   end

   device_store #(.AW(REF_W), .DW(WORD_W)) u_store (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .rd_en(mem_re),
      .wr_en(mem_we),
      .addr(mem_addr),
      .wdata(mem_wdata),
      .rdata(mem_rdata)
   );

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   a_type_mix_err: assert property (
      start_pulse && op_code == OP_RANGE_CLEAR && ta != DEV_X && ta != tb
      |=> error_flag && error_code_register == ERR_TYPE_MIX)
      else $error("range type mismatch not flagged");
   a_err_no_write: assert property (
      start_pulse && l_err |=> st_reg == S_DONE && !mem_we ##1
      st_reg == S_IDLE)
      else $error("faulty instruction touched memory");
   a_err_hold: assert property (
      error_flag && !err_clear |=> error_flag)
      else $error("error indication dropped");
   a_once_per_edge: assert property (
      st_reg == S_IDLE && drive_d_reg && drive_condition
      |=> st_reg == S_IDLE)
      else $error("instruction ran without an edge");
   a_single_clear: assert property (
      start_pulse && op_code == OP_RANGE_CLEAR && !l_err && ia > ib
      |=> s_cnt_reg == CNT_W'(1))
      else $error("reversed range clears more than one");
   a_clear_zero: assert property (
      op_reg == OP_RANGE_CLEAR && (st_reg == S_WR || st_reg == S_WT)
      |-> mem_we && (st_reg == S_WR ? mem_wdata == 16'h0000
         : !mem_wdata[wbit]))
      else $error("range clear wrote a one");
   a_decode_hot: assert property (
      st_reg == S_WR && op_reg == OP_DECODE
      |-> $onehot(mem_wdata) && mem_wdata[res_reg[3:0]])
      else $error("decoded word not one hot");
   a_n_range: assert property (
      start_pulse && op_code == OP_DECODE && length_n > N_MAX_BIT
      |=> error_flag ##1 st_reg == S_IDLE)
      else $error("decode length out of range accepted");
   a_enc_top: assert property (
      st_reg == S_WR && op_reg == OP_ENCODE &&
      !is_bit(a_reg[REF_W-1 -: TYPE_W])
      |-> (enc_field >> mem_wdata[3:0]) == 16'h0001)
      else $error("encoder did not pick the top bit");
   a_sum_high: assert property (
      st_reg == S_WR && op_reg == OP_BIT_COUNT && k_reg == CNT_W'(1)
      |-> mem_wdata == 16'h0000 ##1 st_reg == S_DONE)
      else $error("high count word not zero");
   a_zero_flag: assert property (
      st_reg == S_CALC && op_reg == OP_BIT_COUNT && !wide_reg
      |=> zero_flag == (gword_reg[15:0] == 16'h0000))
      else $error("zero flag wrong after bit count");

endmodule : plc_bit_data_processing_unit

// ### tb/tb_plc_bit_data_processing_unit.sv
`timescale 1ns/1ps

module tb_plc_bit_data_processing_unit;
   import plc_dp_pkg::*;
   // ------------------------------------------------------------
   // stimulus, observed outputs and counters
   // ------------------------------------------------------------
   localparam int RW = TYPE_W + 10; // reference width for IDX_W = 10
   logic sys_clk = 1'b0;
   logic nrst = 1'b0; // held low for three edges at start
   logic drive_condition = 1'b0;
   logic [1:0] op_code = 2'h0;
   logic wide_mode = 1'b0;
   logic [RW-1:0] opd_a = 13'h0000;
   logic [RW-1:0] opd_b = 13'h0000;
   logic [7:0] length_n = 8'h00;
   logic err_clear = 1'b0;
   logic [RW-1:0] host_addr = 13'h0000;
   logic host_rd = 1'b0;
   logic host_wr = 1'b0;
   logic [15:0] host_wdata = 16'h0000;
   logic [15:0] host_rdata;
   logic busy;
   logic done;
   logic zero_flag;
   logic error_flag;
   logic [15:0] error_code_register;
   int err_count = 0;
   int tests_run = 0;

   // 200 MHz scan clock
   always #2.5 sys_clk = ~sys_clk;

   plc_bit_data_processing_unit #(.IDX_W(10), .C32_BASE(200)) uut (
      .sys_clk(sys_clk), .nrst(nrst), .drive_condition(drive_condition),
      .op_code(op_code), .wide_mode(wide_mode), .opd_a(opd_a),
      .opd_b(opd_b), .length_n(length_n), .err_clear(err_clear),
      .host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr),
      .host_wdata(host_wdata), .host_rdata(host_rdata), .busy(busy),
      .done(done), .zero_flag(zero_flag), .error_flag(error_flag),
      .error_code_register(error_code_register));

   // ------------------------------------------------------------
   // shared helpers
   // ------------------------------------------------------------
   // device reference {type, index}
   function automatic logic [RW-1:0] rf(input logic [2:0] t, input int i);
      return {t, i[9:0]};
   endfunction : rf

   task automatic chk(input string nm, input logic [15:0] exp,
      input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // scan-side memory write, only honoured while idle
   task automatic hw(input logic [RW-1:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      host_addr <= a;
      host_wdata <= d;
      host_wr <= 1'b1;
      @(posedge sys_clk);
      host_wr <= 1'b0;
   endtask : hw

   // read data is registered, so it lands on the edge that takes rd
   task automatic hr(input string nm, input logic [RW-1:0] a,
      input logic [15:0] exp);
      @(posedge sys_clk);
      host_addr <= a;
      host_rd <= 1'b1;
      @(posedge sys_clk);
      host_rd <= 1'b0;
      #1;
      chk(nm, exp, host_rdata);
   endtask : hr

   // one instruction; keep leaves the drive high to test edge starts
   task automatic run(input logic [1:0] op, input logic [RW-1:0] a,
      input logic [RW-1:0] b, input logic [7:0] n, input logic w,
      input bit keep);
      int k;
      @(posedge sys_clk);
      op_code <= op;
      opd_a <= a;
      opd_b <= b;
      length_n <= n;
      wide_mode <= w;
      drive_condition <= 1'b1;
      for (k = 0; k < 3000; k++) begin
         @(posedge sys_clk);
         #1;
         if (done === 1'b1) break;
      end
      chk("done", 16'h0001, {15'h0000, done});
      // busy stays up through the done cycle
      chk("busy", 16'h0001, {15'h0000, busy});
      if (!keep) begin
         @(posedge sys_clk);
         drive_condition <= 1'b0;
      end
   endtask : run

   // faulty run: destination kept, flag and code held until cleared
   task automatic ecase(input string nm, input logic [1:0] op,
      input logic [RW-1:0] a, input logic [RW-1:0] b,
      input logic [7:0] n, input logic [15:0] code);
      logic [RW-1:0] dst;
      // a range clear would write its start operand, not its end
      dst = (op == OP_RANGE_CLEAR) ? a : b;
      hw(dst, 16'h5A5A);
      run(op, a, b, n, 1'b0, 1'b0);
      hr(nm, dst, 16'h5A5A);
      chk(nm, 16'h0001, {15'h0000, error_flag});
      chk(nm, code, error_code_register);
      @(posedge sys_clk);
      err_clear <= 1'b1;
      @(posedge sys_clk);
      err_clear <= 1'b0;
      #1;
      chk(nm, 16'h0000, error_code_register | {15'h0000, error_flag});
   endtask : ecase

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_clear;
      int i;
      for (i = 9; i <= 21; i++) hw(rf(DEV_D, i), 16'hFFFF);
      run(OP_RANGE_CLEAR, rf(DEV_D, 10), rf(DEV_D, 12), 8'h00, 1'b0, 1'b0);
      run(OP_RANGE_CLEAR, rf(DEV_D, 20), rf(DEV_D, 18), 8'h00, 1'b0, 1'b0);
      // bit devices: clear bits two to four of one stored word
      hw(rf(DEV_M, 1), 16'hFFFF);
      run(OP_RANGE_CLEAR, rf(DEV_M, 18), rf(DEV_M, 20), 8'h00, 1'b0, 1'b0);
      hr("below", rf(DEV_D, 9), 16'hFFFF);
      for (i = 10; i <= 12; i++) hr("range", rf(DEV_D, i), 16'h0000);
      hr("above", rf(DEV_D, 13), 16'hFFFF);
      hr("rev_start", rf(DEV_D, 20), 16'h0000);
      hr("rev_next", rf(DEV_D, 19), 16'hFFFF);
      hr("bit_clr", rf(DEV_M, 1), 16'hFFE3);
      $display("test range clear finished");
   endtask : t_clear

   task automatic t_err;
      hw(rf(DEV_D, 70), 16'h0000);
      ecase("mix", OP_RANGE_CLEAR, rf(DEV_D, 1), rf(DEV_W, 5), 8'h00,
         ERR_TYPE_MIX);
      ecase("c32", OP_RANGE_CLEAR, rf(DEV_C, 199), rf(DEV_C, 201), 8'h00,
         ERR_TYPE_MIX);
      ecase("n_word", OP_DECODE, rf(DEV_D, 30), rf(DEV_D, 71), 8'h05,
         ERR_OPERAND);
      ecase("n_nine", OP_ENCODE, rf(DEV_D, 30), rf(DEV_D, 72), 8'h09,
         ERR_OPERAND);
      ecase("enc_zero", OP_ENCODE, rf(DEV_D, 70), rf(DEV_D, 73), 8'h04,
         ERR_OPERAND);
      $display("test operand faults finished");
   endtask : t_err

   task automatic t_code;
      hw(rf(DEV_D, 30), 16'h00F7);
      hw(rf(DEV_D, 40), 16'h0012);
      hw(rf(DEV_D, 31), 16'hFFFF);
      hw(rf(DEV_D, 33), 16'hFFFF);
      hw(rf(DEV_M, 2), 16'hFFFF);
      hw(rf(DEV_M, 3), 16'h0025);
      run(OP_DECODE, rf(DEV_D, 30), rf(DEV_D, 31), 8'h02, 1'b0, 1'b0);
      hr("one_hot_decode_n2", rf(DEV_D, 31), 16'h0008);
      run(OP_DECODE, rf(DEV_D, 30), rf(DEV_D, 32), 8'h04, 1'b0, 1'b0);
      hr("one_hot_decode_n4", rf(DEV_D, 32), 16'h0080);
      run(OP_DECODE, rf(DEV_D, 30), rf(DEV_D, 33), 8'h00, 1'b0, 1'b0);
      hr("one_hot_decode_n0", rf(DEV_D, 33), 16'hFFFF);
      chk("n0_err", 16'h0000, {15'h0000, error_flag});
      run(OP_ENCODE, rf(DEV_D, 40), rf(DEV_D, 41), 8'h04, 1'b0, 1'b0);
      hr("priority_encode_n4", rf(DEV_D, 41), 16'h0004);
      run(OP_ENCODE, rf(DEV_D, 40), rf(DEV_D, 42), 8'h01, 1'b0, 1'b0);
      hr("priority_encode_n1", rf(DEV_D, 42), 16'h0001);
      // bit destinations and bit sources take the per-bit paths
      run(OP_DECODE, rf(DEV_D, 30), rf(DEV_M, 32), 8'h02, 1'b0, 1'b0);
      hr("one_hot_decode_bit", rf(DEV_M, 2), 16'hFFF8);
      run(OP_DECODE, rf(DEV_M, 48), rf(DEV_D, 34), 8'h02, 1'b0, 1'b0);
      hr("one_hot_decode_src", rf(DEV_D, 34), 16'h0002);
      run(OP_ENCODE, rf(DEV_M, 48), rf(DEV_D, 43), 8'h03, 1'b0, 1'b0);
      hr("priority_encode_bit", rf(DEV_D, 43), 16'h0005);
      $display("test decode and encode finished");
   endtask : t_code

   task automatic t_count;
      hw(rf(DEV_D, 50), 16'h0F0F);
      hw(rf(DEV_D, 52), 16'h0000);
      hw(rf(DEV_D, 54), 16'hFFFF);
      hw(rf(DEV_D, 55), 16'h0001);
      hw(rf(DEV_D, 57), 16'hFFFF);
      run(OP_BIT_COUNT, rf(DEV_D, 50), rf(DEV_D, 51), 8'h00, 1'b0, 1'b0);
      hr("sum", rf(DEV_D, 51), 16'h0008);
      chk("zf_clr", 16'h0000, {15'h0000, zero_flag});
      run(OP_BIT_COUNT, rf(DEV_D, 52), rf(DEV_D, 53), 8'h00, 1'b0, 1'b0);
      hr("sum_zero", rf(DEV_D, 53), 16'h0000);
      chk("zf_set", 16'h0001, {15'h0000, zero_flag});
      run(OP_BIT_COUNT, rf(DEV_D, 54), rf(DEV_D, 56), 8'h00, 1'b1, 1'b0);
      hr("wide_lo", rf(DEV_D, 56), 16'h0011);
      hr("wide_hi", rf(DEV_D, 57), 16'h0000);
      $display("test bit count finished");
   endtask : t_count

   // a drive that stays high must not start a second run
   task automatic t_edge;
      int k;
      int extra;
      extra = 0;
      hw(rf(DEV_D, 60), 16'hFFFF);
      run(OP_RANGE_CLEAR, rf(DEV_D, 60), rf(DEV_D, 60), 8'h00, 1'b0, 1'b1);
      hw(rf(DEV_D, 60), 16'hFFFF);
      for (k = 0; k < 20; k++) begin
         @(posedge sys_clk);
         #1;
         if (done !== 1'b0) extra++;
      end
      chk("rerun", 16'h0000, extra[15:0]);
      hr("held", rf(DEV_D, 60), 16'hFFFF);
      @(posedge sys_clk);
      drive_condition <= 1'b0;
      $display("test single run per edge finished");
   endtask : t_edge

   // ------------------------------------------------------------
   // sequence, watchdog and verdict
   // ------------------------------------------------------------
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   initial begin
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk("rst_code", 16'h0000, error_code_register);
      chk("rst_flags", 16'h0000, {12'h000, busy, done, zero_flag, error_flag});
      t_clear;
      t_err;
      t_code;
      t_count;
      t_edge;
      give_verdict;
   end

   // the tests need a few hundred cycles; this is far beyond that
   initial begin
      #100000;
      err_count++;
      give_verdict;
   end
endmodule : tb_plc_bit_data_processing_unit
